// >>> hw/sbir_responder.sv
// Init and status command responder with AXI4-Lite configuration registers
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Init answer: address, zeros, fault, OTP, switch, bank
// - Unprogrammed device takes and reports requested address
// - Init assigning address zero is ignored
// - Invalid bank pair: no init response
// - Switch bit closes switch after a fault-free bus test, echoed in answers
// - OTP enable bit reported, 1 enabled
// - Bus fault bit from init bus test
// - Status accepted in all four formats
// - Code 0001 decodes as status request
// - Status ignored while node address is zero
// - Status data bits only feed CRC check
// - Status with foreign address is ignored
// - Short status layout, eight bits plus CRC
// - Long status adds node address on top
// - Error bit follows internal error detection
// - Self-test bit follows self-test activity
// - Undervoltage bit from hold-cap comparator
// - Attribute bits copied from config register
// - Padding matches response to command length
// - Init only standard long; nothing else before
// - Address fields must match programmed or zero
// - Bus test, conditional close, blanking only after a close
// - Further init commands ignored once initialized
module sbir_responder
  import sbir_pkg::*;
#(
  parameter int BLANK_CNT = BLANK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Decoded command from the bus receiver
  input  wire sbir_cmd_s   cmd,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  // Response to the bus transmitter
  output sbir_rsp_s        rsp,
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  // OTP preprogramming, same clock
  input  wire logic        otp_id_valid,
  input  wire logic [3:0]  otp_id,
  // Device state, same clock
  input  wire logic        internal_error,
  input  wire logic        diag_active_flag,
  // Analog pins, asynchronous
  input  wire logic        reserve_cap_low,
  input  wire logic        bus_test_done,
  input  wire logic        downstream_short_high,
  // Bus test and switch control, OTP enable and bank select
  output logic             bus_test_req,
  output logic             bus_switch_closed,
  output logic             otp_write_enabled,
  output logic [1:0]       bank_select
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] cap_sync;
  logic [1:0] done_sync;
  logic [1:0] short_sync;

  // Two flops each; only the second stage is read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cap_sync   <= 2'b00;
      done_sync  <= 2'b00;
      short_sync <= 2'b00;
    end else begin
      cap_sync   <= {cap_sync[0], reserve_cap_low};
      done_sync  <= {done_sync[0], bus_test_done};
      short_sync <= {short_sync[0], downstream_short_high};
    end
  end

  wire logic cap_low_s   = cap_sync[1];
  wire logic test_done_s = done_sync[1];
  wire logic short_s     = short_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state

  sbir_state_e state;
  sbir_state_e next_state;
  logic [31:0] config_reg;
  logic [15:0] drop_count;
  logic        initialized;
  logic [3:0]  assigned_node_id;
  logic        bus_fault_flag;
  logic        switch_req;
  logic [31:0] blank_cnt;
  logic [4:0]  init_len;

  wire logic [1:0] user_tag_pair = config_reg[CFG_TAG_LSB +: 2];
  wire logic [3:0] bank_ok_mask  = config_reg[CFG_BANK_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode

  // Status word, low byte shared by short and long layouts
  function automatic logic [7:0] status_low(input logic otp, input logic uv,
                                            input logic diag, input logic sw,
                                            input logic [1:0] tag, input logic err);
    status_low = {otp, uv, diag, sw, tag, err, 1'b0};
  endfunction : status_low

  wire logic       take        = cmd_valid && cmd_ready;
  wire logic [3:0] req_id      = cmd.data[3:0];
  wire logic [1:0] req_bank    = cmd.data[5:4];
  wire logic       req_switch  = cmd.data[6];
  wire logic       req_otp     = cmd.data[7];

  // Drop everything whose CRC failed before looking further
  wire logic crc_good  = cmd.crc_ok;

  // Init: standard long only, and only while still uninitialized
  wire logic init_fmt  = (cmd.code == CMD_INIT) && cmd.long_fmt
                         && !cmd.enhanced;
  wire logic init_open = !initialized;
  wire logic id_nonzero = (req_id != GLOBAL_ID);
  wire logic bank_ok   = bank_ok_mask[req_bank];
  // Preprogrammed: both fields match; otherwise addressed globally
  wire logic addr_ok   = otp_id_valid ? ((cmd.addr == otp_id) && (req_id == otp_id))
                                      : (cmd.addr == GLOBAL_ID);
  wire logic init_hit  = take && crc_good && init_fmt && init_open
                         && id_nonzero && bank_ok && addr_ok;

  // Status: any of the four formats, only with an own nonzero address
  wire logic stat_code = (cmd.code == CMD_STATUS);
  wire logic stat_addr = (assigned_node_id != GLOBAL_ID)
                         && (cmd.addr == assigned_node_id);
  // Data byte is not consulted; it only entered the receiver's CRC check
  wire logic stat_hit  = take && crc_good && initialized && stat_code
                         && stat_addr;

  wire logic dropped   = take && !init_hit && !stat_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Response words

  wire logic [7:0]  low_byte = status_low(otp_write_enabled, cap_low_s,
                                          diag_active_flag,
                                          bus_switch_closed,
                                          user_tag_pair,
                                          internal_error);
  wire logic [15:0] stat_short = {8'h00, low_byte};
  wire logic [15:0] stat_long  = {assigned_node_id, 4'h0, low_byte};
  // Init answer built from latched fields once the bus test is over
  wire logic [15:0] init_word  = {assigned_node_id, 3'b000, bus_fault_flag,
                                  otp_write_enabled, switch_req, bank_select,
                                  assigned_node_id};

  ////////////////////////////////////////////////////////////////////////////////
  // Controller

  // Commands are accepted only while idle, so blanking also masks the bus
  assign cmd_ready = (state == SBIR_IDLE);

  // Next-state selection
  always_comb begin
    next_state = state;
    unique case (state)
      SBIR_IDLE: begin
        if (init_hit) begin
          next_state = SBIR_TEST;
        end
      end
      SBIR_TEST: begin
        if (test_done_s) begin
          next_state = SBIR_RESP;
        end
      end
      SBIR_RESP: begin
        if (rsp_ready) begin
          next_state = (switch_req && !bus_fault_flag) ? SBIR_BLANK : SBIR_IDLE;
        end
      end
      SBIR_BLANK: begin
        if (blank_cnt == 32'd0) begin
          next_state = SBIR_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= SBIR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bus test request held until the analog test reports done
  assign bus_test_req = (state == SBIR_TEST);

  // Init fields latched on a valid init command
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      initialized       <= 1'b0;
      assigned_node_id  <= 4'h0;
      otp_write_enabled <= 1'b0;
      switch_req        <= 1'b0;
      bank_select       <= 2'b00;
      init_len          <= INIT_RSP_LEN;
    end else if (init_hit) begin
      initialized       <= 1'b1;
      assigned_node_id  <= req_id;
      otp_write_enabled <= req_otp;
      switch_req        <= req_switch;
      bank_select       <= req_bank;
      init_len          <= cmd.msg_len;
    end
  end

  // Fault flag from the bus test; switch closes only on a clean test
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus_fault_flag    <= 1'b0;
      bus_switch_closed <= 1'b0;
    end else if (state == SBIR_TEST && test_done_s) begin
      bus_fault_flag    <= short_s;
    end else if (state == SBIR_RESP && rsp_ready && switch_req && !bus_fault_flag) begin
      bus_switch_closed <= 1'b1;
    end
  end

  // Blanking timer loaded as the switch closes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      blank_cnt <= 32'd0;
    end else if (state == SBIR_RESP) begin
      blank_cnt <= 32'(BLANK_CNT - 1);
    end else if (state == SBIR_BLANK && blank_cnt != 32'd0) begin
      blank_cnt <= blank_cnt - 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Response output

  // Status answers go out the cycle after acceptance; init after its bus test.
  // The answer length equals the command length; unused high bits pad as zero.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else if (rsp_valid && rsp_ready) begin
      rsp_valid <= 1'b0;
    end else if (stat_hit) begin
      rsp_valid   <= 1'b1;
      rsp.data    <= cmd.long_fmt ? stat_long : stat_short;
      rsp.len     <= cmd.msg_len;
      rsp.crc_len <= cmd.crc_len;
    end else if (state == SBIR_TEST && test_done_s) begin
      rsp_valid   <= 1'b1;
      rsp.data    <= {init_word[15:9], short_s, init_word[7:0]};
      rsp.len     <= init_len;
      rsp.crc_len <= INIT_CRC_LEN;
    end
  end

  // Status answers need no idle wait; an unconsumed one holds the next command
  // off only through the receiver's own pacing, as commands come one per frame.

  ////////////////////////////////////////////////////////////////////////////////
  // Dropped-command counter

  // Saturates so software can see a storm of rejects without wrap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      drop_count <= 16'h0000;
    end else if (dropped && drop_count != 16'hFFFF) begin
      drop_count <= drop_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  wire logic        aw_now   = aw_held || s_axi_awvalid;
  wire logic        w_now    = w_held || s_axi_wvalid;
  wire logic [7:0]  wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  wire logic [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
  wire logic [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;
  wire logic        wr_fire  = aw_now && w_now && !s_axi_bvalid;
  wire logic        wr_cfg   = (wr_addr == OFS_CONFIG);
  wire logic        wr_known = wr_cfg || (wr_addr == OFS_STATUS)
                               || (wr_addr == OFS_DROPS);

  // Address and data are captured in either order
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Config write with byte lanes; status and counter are read-only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      config_reg <= CFG_RESET;
    end else if (wr_fire && wr_cfg) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) begin
          config_reg[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [31:0] status_word;

  // Live device state for software
  always_comb begin
    status_word                       = 32'h0000_0000;
    status_word[ST_INIT_BIT]          = initialized;
    status_word[ST_SWITCH_BIT]        = bus_switch_closed;
    status_word[ST_OTP_BIT]           = otp_write_enabled;
    status_word[ST_FAULT_BIT]         = bus_fault_flag;
    status_word[ST_BLANK_BIT]         = (state == SBIR_BLANK);
    status_word[ST_BANK_LSB +: 2]     = bank_select;
    status_word[ST_ID_LSB +: 4]       = assigned_node_id;
  end

  wire logic rd_cfg  = (s_axi_araddr == OFS_CONFIG);
  wire logic rd_stat = (s_axi_araddr == OFS_STATUS);
  wire logic rd_drop = (s_axi_araddr == OFS_DROPS);

  assign s_axi_arready = !s_axi_rvalid;

  // One read at a time; answer one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_cfg  ? config_reg :
                      rd_stat ? status_word :
                      rd_drop ? {16'h0000, drop_count} : 32'h0000_0000;
      s_axi_rresp  <= (rd_cfg || rd_stat || rd_drop) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : sbir_responder

// >>> include/sbir_pkg.sv
// Shared constants, encodings and carriers for the sensor bus init/status responder
package sbir_pkg;

  // Command codes in the four-bit command field, and the global address
  localparam logic [3:0] CMD_INIT   = 4'h0;
  localparam logic [3:0] CMD_STATUS = 4'h1;
  localparam logic [3:0] GLOBAL_ID  = 4'h0;

  // Response lengths and CRC lengths in bits
  localparam logic [4:0] INIT_RSP_LEN = 5'h10;
  localparam logic [3:0] INIT_CRC_LEN = 4'h4;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DROPS  = 8'h08;

  // Config register field positions and reset value
  localparam int            CFG_TAG_LSB   = 0;
  localparam int            CFG_BANK_LSB  = 4;
  localparam logic [31:0]   CFG_RESET     = 32'h0000_00F0;

  // Status register field positions
  localparam int ST_INIT_BIT   = 0;
  localparam int ST_SWITCH_BIT = 1;
  localparam int ST_OTP_BIT    = 2;
  localparam int ST_FAULT_BIT  = 3;
  localparam int ST_BLANK_BIT  = 4;
  localparam int ST_BANK_LSB   = 8;
  localparam int ST_ID_LSB     = 12;

  // Blanking time after switch closure and its cycle count at 250 MHz
  localparam int CLK_MHZ        = 250;
  localparam int T_BLANK_US     = 10;
  localparam int BLANK_CYCLES   = T_BLANK_US * CLK_MHZ;

  // AXI response codes
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Controller states
  typedef enum logic [1:0] {
    SBIR_IDLE  = 2'b00,
    SBIR_TEST  = 2'b01,
    SBIR_RESP  = 2'b10,
    SBIR_BLANK = 2'b11
  } sbir_state_e;

  // Decoded command frame from the bus receiver
  typedef struct packed {
    logic [7:0] data;
    logic [3:0] addr;
    logic [3:0] code;
    logic       long_fmt;
    logic       enhanced;
    logic [4:0] msg_len;
    logic [3:0] crc_len;
    logic       crc_ok;
  } sbir_cmd_s;

  // Response frame to the bus transmitter
  typedef struct packed {
    logic [15:0] data;
    logic [4:0]  len;
    logic [3:0]  crc_len;
  } sbir_rsp_s;

endpackage : sbir_pkg

// >>> verif/sbir_responder_asserts.sv
// Checker for the responder's command, answer and switch behaviour
module sbir_responder_asserts
  import sbir_pkg::*;
(
  // Clock and reset
  input wire logic      clk_sys,
  input wire logic      arst_n,
  // Command side
  input wire sbir_cmd_s cmd,
  input wire logic      cmd_valid,
  input wire logic      cmd_ready,
  // Answer side
  input wire sbir_rsp_s rsp,
  input wire logic      rsp_valid,
  input wire logic      rsp_ready,
  // Device state and switch
  input wire logic      internal_error,
  input wire logic      diag_active_flag,
  input wire logic      bus_test_req,
  input wire logic      bus_switch_closed,
  input wire logic      otp_write_enabled
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // Init: test only after a good init, answer layout, switch gating
  a_test_start: assert property (
    $rose(bus_test_req) |-> $past(cmd_valid && cmd_ready && cmd.crc_ok && cmd.code == CMD_INIT))
    else $error("bus test without accepted init");
  a_crc_drop: assert property (
    cmd_valid && cmd_ready && !cmd.crc_ok |=> !rsp_valid && !bus_test_req)
    else $error("bad checksum command was acted on");
  a_init_layout: assert property (
    $rose(rsp_valid) && $past(bus_test_req) |-> rsp.crc_len == INIT_CRC_LEN
      && rsp.data[15:12] == rsp.data[3:0] && rsp.data[11:9] == 3'h0)
    else $error("init answer layout wrong");
  a_init_nonzero: assert property (
    $rose(rsp_valid) && $past(bus_test_req) |-> rsp.data[3:0] != GLOBAL_ID)
    else $error("init answered with address zero");
  a_switch_fault: assert property (
    $rose(bus_switch_closed) |-> $past(rsp_valid && rsp_ready && rsp.data[6] && !rsp.data[8]))
    else $error("switch closed without request or despite fault");
  // A stalled answer must not change under the far side's feet
  a_rsp_hold: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("answer changed while pending");
  ////////////////////////////////////////
  // Status answers rise one cycle after acceptance
  a_stat_len: assert property (
    $rose(rsp_valid) && !$past(bus_test_req) |-> rsp.len == $past(cmd.msg_len)
      && rsp.crc_len == $past(cmd.crc_len))
    else $error("status answer length wrong");
  a_stat_bits: assert property (
    $rose(rsp_valid) && !$past(bus_test_req) |-> rsp.data[1] == $past(internal_error)
      && rsp.data[5] == $past(diag_active_flag) && rsp.data[0] == 1'b0
      && rsp.data[4] == bus_switch_closed && rsp.data[7] == otp_write_enabled)
    else $error("status flag bits wrong");
  a_short_zero: assert property (
    $rose(rsp_valid) && !$past(bus_test_req) && !$past(cmd.long_fmt) |-> rsp.data[15:8] == 8'h00)
    else $error("short status upper bits not zero");
  a_long_zero: assert property (
    $rose(rsp_valid) && !$past(bus_test_req) && $past(cmd.long_fmt) |-> rsp.data[11:8] == 4'h0)
    else $error("long status gap bits not zero");
endmodule : sbir_responder_asserts

bind sbir_responder sbir_responder_asserts sbir_responder_asserts_inst (
  .clk_sys, .arst_n, .cmd, .cmd_valid, .cmd_ready, .rsp, .rsp_valid, .rsp_ready,
  .internal_error, .diag_active_flag, .bus_test_req, .bus_switch_closed, .otp_write_enabled
);

// >>> verif/sbir_master_model.sv
// Behavioural bus master controller: sends decoded commands, takes answers
module sbir_master_model
  import sbir_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      arst_n,
  // Command towards the device
  output sbir_cmd_s      cmd,
  output logic           cmd_valid,
  input  wire logic      cmd_ready,
  // Answer from the device
  input  wire sbir_rsp_s rsp,
  input  wire logic      rsp_valid,
  output logic           rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int         n_rsp;
  sbir_rsp_s  last;
  logic       slow;
  logic [1:0] ph;
  initial begin
    cmd = '0;
    {cmd_valid, rsp_ready, slow, ph} = '0;
    n_rsp = 0;
  end
  // A slow master listens one cycle in four, to exercise held answers
  always @(posedge clk_sys) begin
    ph <= ph + 2'h1;
    rsp_ready <= arst_n && (!slow || ph == 2'h0);
    if (rsp_valid && rsp_ready) begin
      n_rsp <= n_rsp + 1;
      last <= rsp;
    end
  end
  // One command at a time, never over a pending answer; frame scrambled after
  task automatic send(input sbir_cmd_s c);
    while (rsp_valid) @(posedge clk_sys);
    cmd <= c;
    cmd_valid <= 1'b1;
    do @(posedge clk_sys); while (!cmd_ready);
    cmd_valid <= 1'b0;
    cmd <= ~c;
  endtask : send
endmodule : sbir_master_model

// >>> verif/sbir_responder_bench.sv
// Self-checking bench for the init and status responder
module sbir_responder_bench import sbir_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, cmd_valid, cmd_ready, rsp_valid, rsp_ready, otp_id_valid;
  logic        internal_error, diag_active_flag, reserve_cap_low, bus_test_done;
  logic        downstream_short_high, bus_test_req, bus_switch_closed, otp_write_enabled;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, otp_id;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bank_select;
  sbir_cmd_s   cmd;
  sbir_rsp_s   rsp;
  int          num_errors = 0;
  int          n_checks = 0;
  ////////////////////////////////////////
  // Short blanking count keeps the run brief
  sbir_responder #(.BLANK_CNT(8)) sbir_responder_inst (
    .clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cmd, .cmd_valid, .cmd_ready, .rsp, .rsp_valid, .rsp_ready, .otp_id_valid,
    .otp_id, .internal_error, .diag_active_flag, .reserve_cap_low, .bus_test_done,
    .downstream_short_high, .bus_test_req, .bus_switch_closed, .otp_write_enabled,
    .bank_select
  );
  sbir_master_model master_inst (
    .clk_sys, .arst_n, .cmd, .cmd_valid, .cmd_ready, .rsp, .rsp_valid, .rsp_ready
  );
  // Clock, and an analog bus test that finishes one cycle after it starts
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial bus_test_done = 1'b0;
  always @(posedge clk_sys) bus_test_done <= bus_test_req;
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #40000;
    num_errors++;
    report_and_stop();
  end
  ////////////////////////////////////////
  task automatic report_and_stop;
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Register write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    {aw, w} = 2'b11;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (aw || w) begin
      @(posedge clk_sys);
      if (aw && s_axi_awready) aw = 1'b0;
      if (w && s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    check(s_axi_rdata, d);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  function automatic sbir_cmd_s mk(input logic [3:0] c, a, input logic [7:0] d,
                                   input logic lf, en, ok, input logic [4:0] ml);
    mk = '{d, a, c, lf, en, ml, 4'(ml[2:0]), ok};
  endfunction : mk
  // Send one command, then see whether and what the device answered
  task automatic run(input sbir_cmd_s c, input logic e, input logic [15:0] ed);
    int n0;
    n0 = master_inst.n_rsp;
    master_inst.send(c);
    repeat (20) @(posedge clk_sys);
    check(32'(master_inst.n_rsp - n0), {31'h0, e});
    if (e) begin
      check({16'h0, master_inst.last.data}, {16'h0, ed});
      check({27'h0, master_inst.last.len}, {27'h0, c.msg_len});
    end
  endtask : run
  ////////////////////////////////////////
  initial begin
    logic [7:0] lo;
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, otp_id, otp_id_valid} = '0;
    {internal_error, diag_active_flag, reserve_cap_low, downstream_short_high} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_CONFIG, CFG_RESET, AXI_OKAY);
    rd(OFS_STATUS, 32'h0000_0000, AXI_OKAY);
    rd(8'h0C, 32'h0000_0000, AXI_SLVERR);
    // Everything refused before a valid init
    run(mk(CMD_STATUS, 4'h0, 8'h00, 1'b1, 1'b0, 1'b1, 5'h10), 1'b0, 16'h0000);
    run(mk(CMD_INIT, 4'h0, 8'hC5, 1'b1, 1'b0, 1'b0, 5'h10), 1'b0, 16'h0000);
    run(mk(CMD_INIT, 4'h3, 8'hC5, 1'b1, 1'b0, 1'b1, 5'h10), 1'b0, 16'h0000);
    run(mk(CMD_INIT, 4'h0, 8'hC0, 1'b1, 1'b0, 1'b1, 5'h10), 1'b0, 16'h0000);
    run(mk(CMD_INIT, 4'h0, 8'hC5, 1'b1, 1'b1, 1'b1, 5'h10), 1'b0, 16'h0000);
    run(mk(CMD_INIT, 4'h0, 8'hC5, 1'b0, 1'b0, 1'b1, 5'h10), 1'b0, 16'h0000);
    // Only bank 0 valid, attribute pair 2
    wr(OFS_CONFIG, 32'h0000_0012, AXI_OKAY);
    wr(8'h0C, 32'h0000_0000, AXI_SLVERR);
    run(mk(CMD_INIT, 4'h0, 8'hD5, 1'b1, 1'b0, 1'b1, 5'h10), 1'b0, 16'h0000);
    run(mk(CMD_INIT, 4'h0, 8'hC5, 1'b1, 1'b0, 1'b1, 5'h10), 1'b1, 16'h50C5);
    check({31'h0, bus_switch_closed}, 32'h1);
    rd(OFS_STATUS, 32'h0000_5007, AXI_OKAY);
    run(mk(CMD_INIT, 4'h0, 8'hC5, 1'b1, 1'b0, 1'b1, 5'h10), 1'b0, 16'h0000);
    // All four formats, flags varied, slow master on enhanced ones
    for (int i = 0; i < 4; i++) begin
      internal_error <= i[0];
      diag_active_flag <= i[1];
      reserve_cap_low <= !i[0];
      master_inst.slow <= i[1];
      repeat (3) @(posedge clk_sys);
      lo = {1'b1, !i[0], i[1], 1'b1, 2'b10, i[0], 1'b0};
      run(mk(CMD_STATUS, 4'h5, 8'(i * 77), i[0], i[1], 1'b1, 5'(12 + i)), 1'b1,
          i[0] ? {8'h50, lo} : {8'h00, lo});
    end
    run(mk(CMD_STATUS, 4'h6, 8'h00, 1'b1, 1'b0, 1'b1, 5'h10), 1'b0, 16'h0000);
    run(mk(4'h2, 4'h5, 8'h00, 1'b1, 1'b0, 1'b1, 5'h10), 1'b0, 16'h0000);
    run(mk(CMD_STATUS, 4'h5, 8'h00, 1'b1, 1'b0, 1'b0, 5'h10), 1'b0, 16'h0000);
    // Second life: preprogrammed id 9 and a shorted downstream node
    arst_n <= 1'b0;
    otp_id_valid <= 1'b1;
    otp_id <= 4'h9;
    downstream_short_high <= 1'b1;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    run(mk(CMD_INIT, 4'h9, 8'h59, 1'b1, 1'b0, 1'b1, 5'h10), 1'b1, 16'h9159);
    check({31'h0, bus_switch_closed}, 32'h0);
    check({30'h0, bank_select}, 32'h1);
    report_and_stop();
  end
endmodule : sbir_responder_bench
